/* rtl/hdr_pkg.sv */
// Constants, types and register map of the hub descriptor store
// Contract
// - Configuration value one, no configuration string
// - Attributes A0, E0 when hybrid selected
// - Max power byte 32, 2 mA units
// - Interface descriptor: one hub-class endpoint
// - Endpoint 81, interrupt, one byte, FF
// - Port count is ports plus functions
// - Port count 3-5, or 2-4 disabled
// - Characteristics 0D,00 or 15,00 without overcurrent
// - Power-on to power-good byte 32
// - Hub controller current byte 64
// - Removable map 08/18/38 with both ports
// - Removable map 4C/0C/1C port two off
// - Port power mask always FF
// - Strings unavailable until mode enables them
// - String zero: four bytes, language 09,04
// - Manufacturer string 2E bytes long
// - Product string 10 bytes long
// - Last product character from digit setting
// - Both port two lines high disable it
// - Function count from function config register
// - String enable sets device string indices
package hdr_pkg;
   // Register byte addresses
   localparam logic [4:0] ADDR_MODE  = 5'h00;
   localparam logic [4:0] ADDR_PWR   = 5'h04;
   localparam logic [4:0] ADDR_FUNC  = 5'h08;
   localparam logic [4:0] ADDR_DIGIT = 5'h0C;
   localparam logic [4:0] ADDR_REQ   = 5'h10;
   localparam logic [4:0] ADDR_DATA  = 5'h14;
   localparam logic [4:0] ADDR_STAT  = 5'h18;
   // Field positions
   localparam int MODE_STR_BIT   = 0;
   localparam int MODE_NOOC_BIT  = 1;
   localparam int PWR_HYBRID_BIT = 7;
   localparam int DATA_VALID_BIT = 8;
   localparam int DATA_STALL_BIT = 9;
   localparam int STAT_STALL_BIT = 1;
   localparam int STAT_NBR_LSB   = 8;
   localparam int STAT_RM_LSB    = 16;
   // Reset values
   localparam logic [7:0] MODE_RST  = 8'h00;
   localparam logic [7:0] PWR_RST   = 8'h00;
   localparam logic [1:0] FUNC_RST  = 2'h1;
   localparam logic [3:0] DIGIT_RST = 4'h0;
   // Descriptor types and lengths
   localparam logic [7:0] DT_DEVICE = 8'h01;
   localparam logic [7:0] DT_CONFIG = 8'h02;
   localparam logic [7:0] DT_STRING = 8'h03;
   localparam logic [7:0] DT_INTF   = 8'h04;
   localparam logic [7:0] DT_EP     = 8'h05;
   localparam logic [7:0] DT_HUB    = 8'h29;
   localparam logic [7:0] LEN_DEV   = 8'h12;
   localparam logic [7:0] LEN_CFG   = 8'h09;
   localparam logic [7:0] LEN_TOTAL = 8'h19;
   localparam logic [7:0] LEN_INTF  = 8'h09;
   localparam logic [7:0] LEN_EP    = 8'h07;
   localparam logic [7:0] LEN_HUB   = 8'h09;
   localparam logic [7:0] LEN_STR0  = 8'h04;
   localparam logic [7:0] LEN_STR1  = 8'h2E;
   localparam logic [7:0] LEN_STR2  = 8'h10;
   // Field values
   localparam logic [7:0] USB_BCD_LO    = 8'h10;
   localparam logic [7:0] USB_BCD_HI    = 8'h01;
   localparam logic [7:0] HUB_CLASS     = 8'h09;
   localparam logic [7:0] EP0_MPS       = 8'h40;
   localparam logic [7:0] ONE           = 8'h01;
   localparam logic [7:0] STR_MFR_IDX   = 8'h01;
   localparam logic [7:0] STR_PROD_IDX  = 8'h02;
   localparam logic [7:0] ATTR_BUS      = 8'hA0;
   localparam logic [7:0] ATTR_HYB      = 8'hE0;
   localparam logic [7:0] MAX_POWER     = 8'h32;
   localparam logic [7:0] EP_ADDR       = 8'h81;
   localparam logic [7:0] EP_INTR       = 8'h03;
   localparam logic [7:0] EP_INTERVAL   = 8'hFF;
   localparam logic [7:0] HUB_CHAR_OC   = 8'h0D;
   localparam logic [7:0] HUB_CHAR_NOOC = 8'h15;
   localparam logic [7:0] PWR_ON_GOOD   = 8'h32;
   localparam logic [7:0] HUB_CURRENT   = 8'h64;
   localparam logic [7:0] PWR_MASK      = 8'hFF;
   localparam logic [7:0] LANG_LO       = 8'h09;
   localparam logic [7:0] LANG_HI       = 8'h04;
   localparam logic [7:0] DIGIT_OFFSET  = 8'h0E;
   localparam logic [3:0] UNI_DIGIT_NIB = 4'h3;
   localparam logic [7:0] RM_1F  = 8'h08;
   localparam logic [7:0] RM_2F  = 8'h18;
   localparam logic [7:0] RM_3F  = 8'h38;
   localparam logic [7:0] RM_D1F = 8'h4C;
   localparam logic [7:0] RM_D2F = 8'h0C;
   localparam logic [7:0] RM_D3F = 8'h1C;
   // String text, ASCII, manufacturer then product stem
   localparam int ROM_CHARS     = 28;
   localparam int ROM_PROD_BASE = 22;
   localparam logic [8*ROM_CHARS-1:0] ROM_TEXT =
      "Generic SemiconductorsUSBHUB";
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_ANS  = 3'b100
   } hdr_bus_st_t;
   typedef enum logic [2:0] {
      SEL_NONE, SEL_DEV, SEL_CFG, SEL_HUB, SEL_STR0, SEL_STR1, SEL_STR2
   } hdr_sel_t;
endpackage

/* rtl/hdr_rom.sv */
// String character store with registered read data
module hdr_rom #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW    = 5
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Read port
   input  wire logic [AW-1:0]    addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   for (genvar i = 0; i < DEPTH; i++) begin : g_fill
      if (i < hdr_pkg::ROM_CHARS) begin : g_txt
         assign mem[i] =
            hdr_pkg::ROM_TEXT[8*(hdr_pkg::ROM_CHARS-1-i) +: WIDTH];
      end else begin : g_pad
         assign mem[i] = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= mem[addr];
      end
   end
endmodule

/* rtl/hdr_top.sv */
// Hub descriptor store with an Avalon-MM register slave
module hdr_top #(
   parameter logic [15:0] VENDOR_ID  = 16'hA5A5, // Arbitrary value
   parameter logic [15:0] PRODUCT_ID = 16'h5A5A, // Arbitrary value
   parameter logic [7:0]  DEV_REV    = 8'h07     // Arbitrary value
)(
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Port two data line levels
   input  wire logic        dp2_dp_in,
   input  wire logic        dp2_dm_in
);
   hdr_pkg::hdr_bus_st_t st;
   hdr_pkg::hdr_bus_st_t next_st;
   hdr_pkg::hdr_sel_t    sel;
   hdr_pkg::hdr_sel_t    next_sel;
   logic [7:0]  mode_reg;
   logic [7:0]  usb_power_config_reg;
   logic [1:0]  embedded_function_config_reg;
   logic [3:0]  product_digit_setting;
   logic [31:0] req_reg;
   logic [15:0] remaining;
   logic [7:0]  ptr;
   logic        stall;
   logic        port2_dis;
   logic [7:0]  rom_data;

   // Bus decode
   wire acc     = (st == hdr_pkg::ST_ANS);
   wire wr_ok   = ce & acc & avs_write;
   wire rd_ok   = ce & acc & avs_read;
   wire lane0   = avs_byteenable[0];
   wire full_be = (avs_byteenable == 4'hF);
   wire hit_mode  = (avs_address == hdr_pkg::ADDR_MODE);
   wire hit_pwr   = (avs_address == hdr_pkg::ADDR_PWR);
   wire hit_func  = (avs_address == hdr_pkg::ADDR_FUNC);
   wire hit_digit = (avs_address == hdr_pkg::ADDR_DIGIT);
   wire hit_req   = (avs_address == hdr_pkg::ADDR_REQ);
   wire hit_data  = (avs_address == hdr_pkg::ADDR_DATA);
   wire hit_stat  = (avs_address == hdr_pkg::ADDR_STAT);

   // Configuration derived fields
   wire str_en = mode_reg[hdr_pkg::MODE_STR_BIT];
   wire nooc   = mode_reg[hdr_pkg::MODE_NOOC_BIT];
   wire hybrid = usb_power_config_reg[hdr_pkg::PWR_HYBRID_BIT];
   // Zero is not a legal count, so it reads as one
   wire [1:0] nfunc = (embedded_function_config_reg == 2'h0) ?
                      2'h1 : embedded_function_config_reg;
   wire [1:0] ds_ports = port2_dis ? 2'h1 : 2'h2;
   wire [7:0] nbr = {6'h00, ds_ports} + {6'h00, nfunc};
   wire [7:0] rmap = rm_map(port2_dis, nfunc);

   function automatic logic [7:0] rm_map(input logic dis,
                                         input logic [1:0] nf);
      case (nf)
         2'h2:    rm_map = dis ? hdr_pkg::RM_D2F : hdr_pkg::RM_2F;
         2'h3:    rm_map = dis ? hdr_pkg::RM_D3F : hdr_pkg::RM_3F;
         default: rm_map = dis ? hdr_pkg::RM_D1F : hdr_pkg::RM_1F;
      endcase
   endfunction
   function automatic hdr_pkg::hdr_sel_t sel_of(input logic [7:0] ty,
                                                input logic [7:0] ix,
                                                input logic       en);
      sel_of = hdr_pkg::SEL_NONE;
      case (ty)
         hdr_pkg::DT_DEVICE: sel_of = hdr_pkg::SEL_DEV;
         hdr_pkg::DT_CONFIG: sel_of = hdr_pkg::SEL_CFG;
         hdr_pkg::DT_HUB:    sel_of = hdr_pkg::SEL_HUB;
         hdr_pkg::DT_STRING: begin
            if (en && ix == 8'h00) begin
               sel_of = hdr_pkg::SEL_STR0;
            end else if (en && ix == 8'h01) begin
               sel_of = hdr_pkg::SEL_STR1;
            end else if (en && ix == 8'h02) begin
               sel_of = hdr_pkg::SEL_STR2;
            end
         end
         default: sel_of = hdr_pkg::SEL_NONE;
      endcase
   endfunction
   function automatic logic [7:0] len_of(input hdr_pkg::hdr_sel_t s);
      case (s)
         hdr_pkg::SEL_DEV:  len_of = hdr_pkg::LEN_DEV;
         hdr_pkg::SEL_CFG:  len_of = hdr_pkg::LEN_TOTAL;
         hdr_pkg::SEL_HUB:  len_of = hdr_pkg::LEN_HUB;
         hdr_pkg::SEL_STR0: len_of = hdr_pkg::LEN_STR0;
         hdr_pkg::SEL_STR1: len_of = hdr_pkg::LEN_STR1;
         hdr_pkg::SEL_STR2: len_of = hdr_pkg::LEN_STR2;
         default:           len_of = 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] dev_byte(input logic [7:0] p,
                                           input logic en);
      case (p)
         8'h00:   dev_byte = hdr_pkg::LEN_DEV;
         8'h01:   dev_byte = hdr_pkg::DT_DEVICE;
         8'h02:   dev_byte = hdr_pkg::USB_BCD_LO;
         8'h03:   dev_byte = hdr_pkg::USB_BCD_HI;
         8'h04:   dev_byte = hdr_pkg::HUB_CLASS;
         8'h07:   dev_byte = hdr_pkg::EP0_MPS;
         8'h08:   dev_byte = VENDOR_ID[7:0];
         8'h09:   dev_byte = VENDOR_ID[15:8];
         8'h0A:   dev_byte = PRODUCT_ID[7:0];
         8'h0B:   dev_byte = PRODUCT_ID[15:8];
         8'h0D:   dev_byte = DEV_REV;
         8'h0E:   dev_byte = en ? hdr_pkg::STR_MFR_IDX : 8'h00;
         8'h0F:   dev_byte = en ? hdr_pkg::STR_PROD_IDX : 8'h00;
         8'h11:   dev_byte = hdr_pkg::ONE;
         default: dev_byte = 8'h00;
      endcase
   endfunction
   // Configuration, interface and endpoint sent as one block
   function automatic logic [7:0] cfg_byte(input logic [7:0] p,
                                           input logic hyb);
      case (p)
         8'h00:   cfg_byte = hdr_pkg::LEN_CFG;
         8'h01:   cfg_byte = hdr_pkg::DT_CONFIG;
         8'h02:   cfg_byte = hdr_pkg::LEN_TOTAL;
         8'h04:   cfg_byte = hdr_pkg::ONE;
         8'h05:   cfg_byte = hdr_pkg::ONE;
         8'h07:   cfg_byte = hyb ? hdr_pkg::ATTR_HYB
                                 : hdr_pkg::ATTR_BUS;
         8'h08:   cfg_byte = hdr_pkg::MAX_POWER;
         8'h09:   cfg_byte = hdr_pkg::LEN_INTF;
         8'h0A:   cfg_byte = hdr_pkg::DT_INTF;
         8'h0D:   cfg_byte = hdr_pkg::ONE;
         8'h0E:   cfg_byte = hdr_pkg::HUB_CLASS;
         8'h12:   cfg_byte = hdr_pkg::LEN_EP;
         8'h13:   cfg_byte = hdr_pkg::DT_EP;
         8'h14:   cfg_byte = hdr_pkg::EP_ADDR;
         8'h15:   cfg_byte = hdr_pkg::EP_INTR;
         8'h16:   cfg_byte = hdr_pkg::ONE;
         8'h18:   cfg_byte = hdr_pkg::EP_INTERVAL;
         default: cfg_byte = 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] hub_byte(input logic [7:0] p,
                                           input logic [7:0] n,
                                           input logic no_oc,
                                           input logic [7:0] rm);
      case (p)
         8'h00:   hub_byte = hdr_pkg::LEN_HUB;
         8'h01:   hub_byte = hdr_pkg::DT_HUB;
         8'h02:   hub_byte = n;
         8'h03:   hub_byte = no_oc ? hdr_pkg::HUB_CHAR_NOOC
                                   : hdr_pkg::HUB_CHAR_OC;
         8'h05:   hub_byte = hdr_pkg::PWR_ON_GOOD;
         8'h06:   hub_byte = hdr_pkg::HUB_CURRENT;
         8'h07:   hub_byte = rm;
         8'h08:   hub_byte = hdr_pkg::PWR_MASK;
         default: hub_byte = 8'h00;
      endcase
   endfunction

   // Unicode strings: ASCII from the store, high byte zero
   wire [7:0] digit_byte = {hdr_pkg::UNI_DIGIT_NIB,
                            product_digit_setting};
   wire [7:0] str_body =
      ptr[0] ? 8'h00 :
      (sel == hdr_pkg::SEL_STR2 && ptr == hdr_pkg::DIGIT_OFFSET) ?
      digit_byte : rom_data;
   wire [7:0] str_byte =
      (ptr == 8'h00) ? len_of(sel) :
      (ptr == 8'h01) ? hdr_pkg::DT_STRING :
      (sel != hdr_pkg::SEL_STR0) ? str_body :
      (ptr == 8'h02) ? hdr_pkg::LANG_LO : hdr_pkg::LANG_HI;

   wire [7:0] cur_byte =
      (sel == hdr_pkg::SEL_DEV) ? dev_byte(ptr, str_en) :
      (sel == hdr_pkg::SEL_CFG) ? cfg_byte(ptr, hybrid) :
      (sel == hdr_pkg::SEL_HUB) ? hub_byte(ptr, nbr, nooc, rmap) :
      (sel == hdr_pkg::SEL_NONE) ? 8'h00 : str_byte;

   wire [7:0] ch_off = (ptr - 8'h02) >> 1;
   wire [7:0] rom_idx = (sel == hdr_pkg::SEL_STR2) ?
                        ch_off + 8'(hdr_pkg::ROM_PROD_BASE) : ch_off;

   hdr_rom #(
      .WIDTH (8),
      .DEPTH (32),
      .AW    (5)
   ) u_rom (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .addr    (rom_idx[4:0]),
      .rd_data (rom_data)
   );

   // New request, truncated to the shorter of the two lengths
   wire        take_req  = wr_ok & hit_req & full_be;
   assign next_sel = sel_of(avs_writedata[7:0], avs_writedata[15:8],
                            str_en);
   wire [15:0] next_len  = {8'h00, len_of(next_sel)};
   wire [15:0] ask_len   = avs_writedata[31:16];
   wire [15:0] next_rem  = (ask_len < next_len) ? ask_len
                                                : next_len;
   wire        has_byte  = (remaining != 16'h0000);
   wire        step      = rd_ok & hit_data & has_byte;
   wire [31:0] data_word = {22'h0, stall, has_byte,
                            has_byte ? cur_byte : 8'h00};
   wire [31:0] stat_word = {8'h00, rmap, nbr, 6'h00, stall, port2_dis};
   wire [31:0] rd_mux =
      hit_mode  ? {24'h0, mode_reg} :
      hit_pwr   ? {24'h0, usb_power_config_reg} :
      hit_func  ? {30'h0, embedded_function_config_reg} :
      hit_digit ? {28'h0, product_digit_setting} :
      hit_req   ? req_reg :
      hit_data  ? data_word :
      hit_stat  ? stat_word : 32'h0;

   always_comb begin
      case (st)
         hdr_pkg::ST_IDLE: next_st = (avs_read | avs_write) ?
                                     hdr_pkg::ST_WAIT : hdr_pkg::ST_IDLE;
         hdr_pkg::ST_WAIT: next_st = hdr_pkg::ST_ANS;
         hdr_pkg::ST_ANS:  next_st = hdr_pkg::ST_IDLE;
         default:          next_st = hdr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st              <= hdr_pkg::ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else if (ce) begin
         st              <= next_st;
         avs_waitrequest <= (next_st != hdr_pkg::ST_ANS);
         if (st == hdr_pkg::ST_WAIT) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Strap-like pins sampled every cycle that ce is high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         port2_dis <= 1'b0;
      end else if (ce) begin
         port2_dis <= dp2_dp_in & dp2_dm_in;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg                     <= hdr_pkg::MODE_RST;
         usb_power_config_reg         <= hdr_pkg::PWR_RST;
         embedded_function_config_reg <= hdr_pkg::FUNC_RST;
         product_digit_setting        <= hdr_pkg::DIGIT_RST;
      end else if (wr_ok & lane0) begin
         if (hit_mode) begin
            mode_reg <= avs_writedata[7:0];
         end
         if (hit_pwr) begin
            usb_power_config_reg <= avs_writedata[7:0];
         end
         if (hit_func) begin
            embedded_function_config_reg <= avs_writedata[1:0];
         end
         if (hit_digit) begin
            product_digit_setting <= avs_writedata[3:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg   <= 32'h0;
         sel       <= hdr_pkg::SEL_NONE;
         ptr       <= 8'h00;
         remaining <= 16'h0000;
         stall     <= 1'b0;
      end else if (take_req) begin
         req_reg   <= avs_writedata;
         sel       <= next_sel;
         ptr       <= 8'h00;
         remaining <= next_rem;
         stall     <= (next_sel == hdr_pkg::SEL_NONE);
      end else if (step) begin
         ptr       <= ptr + 8'h01;
         remaining <= remaining - 16'h0001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      st == hdr_pkg::ST_IDLE && ce && (avs_read || avs_write);
   endsequence
   sequence s_str_off;
      take_req && avs_writedata[7:0] == hdr_pkg::DT_STRING && !str_en;
   endsequence
   property p_answer;
      s_start ##1 ce |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("answer not two cycles after request");
   property p_attr;
      sel == hdr_pkg::SEL_CFG && ptr == 8'h07 |->
         cur_byte == (hybrid ? 8'hE0 : 8'hA0);
   endproperty
   a_attr: assert property (p_attr)
      else $error("attributes byte wrong");
   property p_nbr;
      port2_dis ? (nbr >= 8'h02 && nbr <= 8'h04)
                : (nbr >= 8'h03 && nbr <= 8'h05);
   endproperty
   a_nbr: assert property (p_nbr)
      else $error("port count out of range");
   property p_rm_both;
      !port2_dis |-> rmap == (nfunc == 2'h1 ? 8'h08 :
                              nfunc == 2'h2 ? 8'h18 : 8'h38);
   endproperty
   a_rm_both: assert property (p_rm_both)
      else $error("removable map wrong");
   property p_rm_dis;
      port2_dis |-> rmap == (nfunc == 2'h1 ? 8'h4C :
                             nfunc == 2'h2 ? 8'h0C : 8'h1C);
   endproperty
   a_rm_dis: assert property (p_rm_dis)
      else $error("removable map wrong with port two off");
   property p_str_gate;
      $rose(str_en) |-> $past(wr_ok && hit_mode);
   endproperty
   a_str_gate: assert property (p_str_gate)
      else $error("string enable rose without a write");
   property p_str_stall;
      s_str_off |=> stall && remaining == 16'h0000;
   endproperty
   a_str_stall: assert property (p_str_stall)
      else $error("string served while disabled");
   property p_order;
      step |=> ptr == $past(ptr) + 8'h01 &&
               remaining == $past(remaining) - 16'h0001;
   endproperty
   a_order: assert property (p_order)
      else $error("pointer did not advance by one");
   property p_trunc;
      take_req |=> remaining <= $past(avs_writedata[31:16]);
   endproperty
   a_trunc: assert property (p_trunc)
      else $error("response longer than requested");
   property p_digit;
      sel == hdr_pkg::SEL_STR2 && ptr == 8'h0E |->
         cur_byte == {4'h3, product_digit_setting};
   endproperty
   a_digit: assert property (p_digit)
      else $error("product digit byte wrong");
   property p_port2;
      // Pins are ignored while reset holds the flop
      $past(ce) && $past(rst_n) |->
         port2_dis == $past(dp2_dp_in && dp2_dm_in);
   endproperty
   a_port2: assert property (p_port2)
      else $error("port two disable not tracking pins");
endmodule

/* tb/hdr_port2_model.sv */
// Board model of the port two data lines
module hdr_port2_model (
   // Board strap
   input  wire logic p2_off,
   // Line levels
   output logic      dp2_dp,
   output logic      dp2_dm
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle device shows J; a strap ties both lines high
   assign dp2_dp = 1'b1;
   assign dp2_dm = p2_off;
endmodule

/* tb/test_hdr_top.sv */
// Self-checking bench of the hub descriptor store
module test_hdr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        p2_off;
   logic        dp2_dp;
   logic        dp2_dm;
   logic [31:0] rd_q;
   logic [7:0]  got[$];
   logic [7:0]  exp[$];
   logic [7:0]  nbr;
   logic [7:0]  rm;
   logic [7:0]  rmt[6] = '{8'h08, 8'h18, 8'h38, 8'h4C, 8'h0C, 8'h1C};
   logic        ce;
   int          waits;
   int          miscompares;
   int          n_compared;

   hdr_top hdr_top_i (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .ce              (ce),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (4'hF),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .dp2_dp_in       (dp2_dp),
      .dp2_dm_in       (dp2_dm)
   );
   hdr_port2_model hdr_port2_model_i (
      .p2_off (p2_off),
      .dp2_dp (dp2_dp),
      .dp2_dm (dp2_dm)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // One access; waitrequest and read data taken at one rising edge
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, avs_waitrequest, 1'b0);
         final_report();
      end
      rd_q = avs_readdata;
      waits = n;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Stream a descriptor until the valid flag drops
   task automatic get(input logic [7:0] t, input logic [7:0] ix,
                      input logic [15:0] len);
      got.delete();
      bus(1'b1, hdr_pkg::ADDR_REQ, {len, ix, t});
      for (int k = 0; k < 64; k++) begin
         bus(1'b0, hdr_pkg::ADDR_DATA, 32'h0);
         if (rd_q[hdr_pkg::DATA_VALID_BIT] !== 1'b1) break;
         got.push_back(rd_q[7:0]);
      end
   endtask

   task automatic cmp();
      chk(32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) chk({24'h0, got[i]}, {24'h0, exp[i]});
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      final_report();
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      p2_off = 1'b0;
      ce = 1'b1;
      waits = 0;
      miscompares = 0;
      n_compared = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, hdr_pkg::ADDR_STAT, 32'h0);
      chk(rd_q, 32'h0008_0300);
      chk(32'(waits), 32'd3);
      bus(1'b0, 5'h1C, 32'h0);
      chk(rd_q, 32'h0);
      $display("test reset done");
      exp = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0,
              8'h32, 8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00,
              8'h00, 8'h00, 8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00,
              8'hFF};
      get(hdr_pkg::DT_CONFIG, 8'h00, 16'h0040);
      cmp();
      bus(1'b1, hdr_pkg::ADDR_PWR, 32'h80);
      get(hdr_pkg::DT_CONFIG, 8'h00, 16'h0008);
      exp = exp[0:7];
      exp[7] = 8'hE0;
      cmp();
      $display("test config done");
      for (int off = 0; off < 2; off++) begin
         for (int f = 1; f < 4; f++) begin
            p2_off <= off[0];
            bus(1'b1, hdr_pkg::ADDR_FUNC, 32'(f));
            bus(1'b1, hdr_pkg::ADDR_MODE, {30'h0, off[0], 1'b0});
            nbr = 8'(f + 2 - off);
            rm = rmt[off * 3 + f - 1];
            exp = '{8'h09, 8'h29, nbr, off ? 8'h15 : 8'h0D, 8'h00, 8'h32,
                    8'h64, rm, 8'hFF};
            get(hdr_pkg::DT_HUB, 8'h00, 16'h0009);
            cmp();
            bus(1'b0, hdr_pkg::ADDR_STAT, 32'h0);
            chk(rd_q, {8'h00, rm, nbr, 7'h00, off[0]});
         end
      end
      $display("test hub done");
      bus(1'b1, hdr_pkg::ADDR_MODE, 32'h0);
      get(hdr_pkg::DT_STRING, 8'h00, 16'h0004);
      chk({30'h0, rd_q[9:8]}, 32'h2);
      get(hdr_pkg::DT_DEVICE, 8'h00, 16'h0012);
      chk({16'h0, got[14], got[15]}, 32'h0);
      bus(1'b1, hdr_pkg::ADDR_MODE, 32'h1);
      bus(1'b1, hdr_pkg::ADDR_DIGIT, 32'h5);
      exp = '{8'h04, 8'h03, 8'h09, 8'h04};
      get(hdr_pkg::DT_STRING, 8'h00, 16'h00FF);
      cmp();
      get(hdr_pkg::DT_STRING, 8'h01, 16'h00FF);
      chk(32'(got.size()), 32'd46);
      chk({16'h0, got[0], got[1]}, 32'h2E03);
      get(hdr_pkg::DT_STRING, 8'h02, 16'h00FF);
      chk(32'(got.size()), 32'd16);
      chk({got[0], got[1], got[14], got[15]}, 32'h1003_3500);
      get(hdr_pkg::DT_DEVICE, 8'h00, 16'h0012);
      chk({16'h0, got[14], got[15]}, 32'h0102);
      $display("test strings done");
      // Reset in mid-run, port two still strapped off
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, hdr_pkg::ADDR_STAT, 32'h0);
      chk(rd_q, 32'h004C_0201);
      get(hdr_pkg::DT_STRING, 8'h01, 16'h00FF);
      chk({30'h0, rd_q[9:8]}, 32'h2);
      // Enable low for five edges delays the answer by four
      ce <= 1'b0;
      fork
         bus(1'b0, hdr_pkg::ADDR_FUNC, 32'h0);
         begin
            repeat (5) @(posedge core_clk);
            ce <= 1'b1;
         end
      join
      chk(32'(waits), 32'd7);
      chk(rd_q, 32'h1);
      $display("test reset again done");
      final_report();
   end
endmodule
